// ==== src/split_bulk_desc_status.sv ====
// Status and retry write-back logic for one split bulk descriptor entry
//
// Functional notes
// [R1] Babble clears the live-entry and entry-in-use bits, retiring the entry.
// [R2] Fault flag mirrors transaction errors; software zeroes it first.
// [R3] Phase bit loaded zero; hardware sets it when complete split follows.
// [R4] Software loads starting toggle; hardware writes toggle back on success.
// [R5] Each missing or bad response decrements retry count; zero retires.
// [R6] NAK or NYET reloads the retry count instead of decrementing it.
// [R7] Software keeps a late retry first by not advancing the entry pointer.
// [R8] Negative-ack count reaching zero with nonzero reload retires the entry.
// [R9] Negative-ack counting never applies to isochronous split entries.
// [R10] Hardware writes the moved byte count of each successful transaction.
// [R11] Zero reload value makes hardware ignore the negative-ack count.
// [R12] Software programs reload as zero for full- and low-speed entries.
// [R13] Software writes live-entry bit equal to the entry-in-use bit.
`timescale 1ns/1ps
`default_nettype none

module split_bulk_desc_status
(
   input  wire logic                                 clk_in,
   input  wire logic                                 nrst_in,
   input  wire logic [split_desc_pkg::ADDR_W-1:0]    addr_in,
   input  wire logic [split_desc_pkg::DATA_W-1:0]    wr_data_in,
   input  wire logic                                 wr_en_in,
   input  wire logic                                 rd_en_in,
   input  wire logic                                 report_valid_in,
   input  wire split_desc_pkg::txn_report_s          report_in,
   output logic      [split_desc_pkg::DATA_W-1:0]    rd_data_out,
   output logic                                      irq_out,
   output logic                                      valid_out,
   output logic                                      active_out,
   output logic                                      split_phase_out,
   output logic                                      toggle_out
);

   // Result of merging one transaction report into the entry
   typedef struct packed
   {
      logic [split_desc_pkg::DATA_W-1:0] word;

      logic                              retire;
      logic                              ev_ok;
      logic                              ev_babble;
      logic                              ev_err;
      logic                              ev_nak;
   } update_s;

   // Address match used by both the write and read decode
   function automatic logic addr_hit
   (
      input logic [split_desc_pkg::ADDR_W-1:0] addr,
      input logic [split_desc_pkg::ADDR_W-1:0] offset
   );
      addr_hit = (addr == offset);
   endfunction

   // Apply one transaction outcome to the status word
   function automatic update_s apply_report
   (
      input logic [split_desc_pkg::DATA_W-1:0] word_in,
      input split_desc_pkg::txn_report_s       rep,
      input logic [split_desc_pkg::NAK_W-1:0]  reload,
      input logic                              iso
   );
      update_s                             u;
      logic [split_desc_pkg::CERR_W-1:0]   cerr;
      logic [split_desc_pkg::NAK_W-1:0]    nak;

      u           = '0;
      u.word      = word_in;
      cerr        = word_in[split_desc_pkg::CERR_LO +:
                            split_desc_pkg::CERR_W];
      nak         = word_in[split_desc_pkg::NAK_LO +:
                            split_desc_pkg::NAK_W];
      case (rep.result)
         split_desc_pkg::RES_BABBLE:
         begin
            // Babble always ends the entry
            u.word[split_desc_pkg::BIT_BABBLE] = 1'b1;
            u.word[split_desc_pkg::BIT_HALT]   = 1'b1;
            u.word[split_desc_pkg::BIT_ACTIVE] = 1'b0; // R1
            u.retire                           = 1'b1; // R1
            u.ev_babble                        = 1'b1;
         end

         split_desc_pkg::RES_NO_RESP,
         split_desc_pkg::RES_BAD:
         begin
            // Fault flag mirrors the error
            u.word[split_desc_pkg::BIT_XACT_ERR] = 1'b1; // R2

            if (cerr <= split_desc_pkg::CERR_ONE)
            begin
               // Last allowed error spends the count
               cerr                               = split_desc_pkg::CERR_ZERO;
               u.word[split_desc_pkg::BIT_HALT]   = 1'b1;
               u.word[split_desc_pkg::BIT_ACTIVE] = 1'b0; // R5
               u.retire                           = 1'b1; // R5
               u.ev_err                           = 1'b1;
            end
            else
            begin
               cerr = cerr - split_desc_pkg::CERR_ONE; // R5
            end
         end

         split_desc_pkg::RES_NAK,
         split_desc_pkg::RES_NYET:
         begin
            // Device answered, so the link itself is healthy
            cerr = split_desc_pkg::CERR_FULL; // R6

            if (rep.result == split_desc_pkg::RES_NAK && !iso &&
                reload != split_desc_pkg::NAK_ZERO) // R9 R11
            begin
               if (nak <= split_desc_pkg::NAK_ONE)
               begin
                  nak = split_desc_pkg::NAK_ZERO;
                  u.word[split_desc_pkg::BIT_ACTIVE] = 1'b0; // R8
                  u.retire                           = 1'b1; // R8
                  u.ev_nak                           = 1'b1;
               end
               else
               begin
                  nak = nak - split_desc_pkg::NAK_ONE; // R8
               end
            end
         end

         default:
         begin
            // Successful handshake
            cerr = split_desc_pkg::CERR_FULL;
            if (!iso)
               nak = reload;
            u.word[split_desc_pkg::BIT_TOGGLE] = rep.next_toggle; // R4
            u.word[split_desc_pkg::BYTES_LO +:
                   split_desc_pkg::BYTES_W]    = rep.byte_count; // R10

            if (!word_in[split_desc_pkg::BIT_PHASE])
            begin
               // Start split accepted: complete split comes next
               u.word[split_desc_pkg::BIT_PHASE] = 1'b1; // R3
            end
            else
            begin
               // Complete split finished the transfer
               u.word[split_desc_pkg::BIT_PHASE]  = 1'b0;
               u.word[split_desc_pkg::BIT_ACTIVE] = 1'b0;
               u.retire                           = 1'b1;
               u.ev_ok                            = 1'b1;
            end
         end
      endcase

      u.word[split_desc_pkg::CERR_LO +: split_desc_pkg::CERR_W] = cerr;
      u.word[split_desc_pkg::NAK_LO +: split_desc_pkg::NAK_W]   = nak;
      u.word = u.word & split_desc_pkg::WORD_USED_MASK;
      return u;
   endfunction

   // Storage
   logic [split_desc_pkg::DATA_W-1:0] entry_word;

   logic                              valid_reg;
   logic                              valid_next;

   logic                              iso_reg;
   logic                              iso_next;

   logic [split_desc_pkg::NAK_W-1:0]  reload_reg;
   logic [split_desc_pkg::NAK_W-1:0]  reload_next;

   logic [split_desc_pkg::IRQ_W-1:0]  irq_status_reg;
   logic [split_desc_pkg::IRQ_W-1:0]  irq_status_next;

   logic [split_desc_pkg::IRQ_W-1:0]  irq_mask_reg;
   logic [split_desc_pkg::IRQ_W-1:0]  irq_mask_next;

   logic [split_desc_pkg::DATA_W-1:0] rd_data_reg;
   logic [split_desc_pkg::DATA_W-1:0] rd_data_next;

   logic                              irq_reg;
   logic                              irq_next;

   // Address decode
   wire logic sel_word;
   wire logic sel_ctl;
   wire logic sel_stat;
   wire logic sel_mask;

   wire logic wr_word;
   wire logic wr_ctl;
   wire logic wr_mask;
   wire logic rd_stat;

   assign sel_word = addr_hit(addr_in, split_desc_pkg::OFF_ENTRY_WORD);
   assign sel_ctl  = addr_hit(addr_in, split_desc_pkg::OFF_CONTROL);
   assign sel_stat = addr_hit(addr_in, split_desc_pkg::OFF_IRQ_STATUS);
   assign sel_mask = addr_hit(addr_in, split_desc_pkg::OFF_IRQ_MASK);

   assign wr_word  = wr_en_in && sel_word;
   assign wr_ctl   = wr_en_in && sel_ctl;
   assign wr_mask  = wr_en_in && sel_mask;
   assign rd_stat  = rd_en_in && sel_stat;

   // Software view of the entry before hardware acts this cycle
   wire logic [split_desc_pkg::DATA_W-1:0] base_word;
   wire logic                              base_valid;
   wire logic                              base_iso;
   wire logic [split_desc_pkg::NAK_W-1:0]  base_reload;

   assign base_word   = wr_word ?
                        (wr_data_in & split_desc_pkg::WORD_USED_MASK) :
                        entry_word;

   assign base_valid  = wr_ctl ? wr_data_in[split_desc_pkg::CTL_VALID_BIT] :
                        valid_reg;

   assign base_iso    = wr_ctl ? wr_data_in[split_desc_pkg::CTL_ISO_BIT] :
                        iso_reg;

   assign base_reload = wr_ctl ?
                        wr_data_in[split_desc_pkg::CTL_RL_LO +:
                                   split_desc_pkg::NAK_W] :
                        reload_reg;

   // Hardware update; a same-cycle software write is merged, not lost.
   // Reports against an entry not in use are ignored.
   wire logic    take_report;
   wire update_s upd;

   assign take_report = report_valid_in && base_valid;
   assign upd = apply_report(base_word, report_in, base_reload, base_iso);

   wire logic [split_desc_pkg::DATA_W-1:0] word_next;
   wire logic                              word_we;

   assign word_next = take_report ? upd.word : base_word;

   assign word_we   = wr_word || take_report;

   desc_word_store
   #(
      .WIDTH     (split_desc_pkg::DATA_W),
      .RESET_VAL (split_desc_pkg::WORD_RESET)
   )
   u_word_store
   (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .wr_en_in   (word_we),
      .wr_data_in (word_next),
      .word_out   (entry_word)
   );

   // Control next values; retirement drops the in-use bit
   assign valid_next  = base_valid && !(take_report && upd.retire); // R1 R5 R8

   assign iso_next    = base_iso;
   assign reload_next = base_reload;
   assign irq_mask_next = wr_mask ? wr_data_in[split_desc_pkg::IRQ_W-1:0] :
                          irq_mask_reg;

   // Events raised by this cycle's report
   wire logic [split_desc_pkg::IRQ_W-1:0] irq_set;

   assign irq_set[split_desc_pkg::IRQ_OK_BIT]     = take_report && upd.ev_ok;

   assign irq_set[split_desc_pkg::IRQ_BABBLE_BIT] = take_report &&
                                                    upd.ev_babble;
   assign irq_set[split_desc_pkg::IRQ_ERR_BIT]    = take_report && upd.ev_err;
   assign irq_set[split_desc_pkg::IRQ_NAK_BIT]    = take_report && upd.ev_nak;

   // Read clears status; an event landing on the read stays pending
   assign irq_status_next = (rd_stat ? '0 : irq_status_reg) | irq_set;

   assign irq_next        = |(irq_status_next & irq_mask_next);

   // Control register image for readback
   wire logic [split_desc_pkg::DATA_W-1:0] ctl_image;

   assign ctl_image = {{(split_desc_pkg::DATA_W - split_desc_pkg::CTL_RL_LO -
                         split_desc_pkg::NAK_W){1'b0}},
                       reload_reg, iso_reg, valid_reg};

   // Read mux; unmapped addresses read zero, data valid only after a strobe
   assign rd_data_next =
      !rd_en_in ? '0 :
      sel_word  ? entry_word :
      sel_ctl   ? ctl_image :
      sel_stat  ? {{(split_desc_pkg::DATA_W - split_desc_pkg::IRQ_W){1'b0}},
                   irq_status_reg} :
      sel_mask  ? {{(split_desc_pkg::DATA_W - split_desc_pkg::IRQ_W){1'b0}},
                   irq_mask_reg} :
      '0;

   // Control and interrupt state
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         valid_reg      <= 1'b0;
         iso_reg        <= 1'b0;
         reload_reg     <= split_desc_pkg::NAK_ZERO;
         irq_status_reg <= '0;
         irq_mask_reg   <= '0;
      end
      else
      begin
         valid_reg      <= valid_next;
         iso_reg        <= iso_next;
         reload_reg     <= reload_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg   <= irq_mask_next;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         rd_data_reg <= '0;
         irq_reg     <= 1'b0;
      end
      else
      begin
         rd_data_reg <= rd_data_next;
         irq_reg     <= irq_next;
      end
   end

   assign rd_data_out     = rd_data_reg;
   assign irq_out         = irq_reg;

   assign valid_out       = valid_reg;
   assign active_out      = entry_word[split_desc_pkg::BIT_ACTIVE];
   assign split_phase_out = entry_word[split_desc_pkg::BIT_PHASE];
   assign toggle_out      = entry_word[split_desc_pkg::BIT_TOGGLE];

endmodule

`default_nettype wire

// ==== src/split_desc_pkg.sv ====
// Shared constants and types for the split bulk descriptor write-back block
package split_desc_pkg;

   // Register port geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_ENTRY_WORD = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_CONTROL    = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 5'h0C;

   // Entry status word layout (bits 26 and 18:15 of the descriptor word are reserved)
   localparam int BIT_ACTIVE   = 31;
   localparam int BIT_HALT     = 30;
   localparam int BIT_BABBLE   = 29;
   localparam int BIT_XACT_ERR = 28;
   localparam int BIT_PHASE    = 27;
   localparam int BIT_TOGGLE   = 25;
   localparam int CERR_LO      = 23;
   localparam int CERR_W       = 2;
   localparam int NAK_LO       = 19;
   localparam int NAK_W        = 4;
   localparam int BYTES_LO     = 0;
   localparam int BYTES_W      = 15;

   // Bits that hold storage; reserved bits read as zero
   localparam logic [DATA_W-1:0] WORD_USED_MASK = 32'hFBF8_7FFF;
   localparam logic [DATA_W-1:0] WORD_RESET     = 32'h0000_0000;

   // Control register layout
   localparam int CTL_VALID_BIT = 0;
   localparam int CTL_ISO_BIT   = 1;
   localparam int CTL_RL_LO     = 2;

   // Interrupt status and mask layout
   localparam int IRQ_W          = 4;
   localparam int IRQ_OK_BIT     = 0;
   localparam int IRQ_BABBLE_BIT = 1;
   localparam int IRQ_ERR_BIT    = 2;
   localparam int IRQ_NAK_BIT    = 3;

   // Counter constants
   localparam logic [CERR_W-1:0] CERR_FULL = 2'h3;
   localparam logic [CERR_W-1:0] CERR_ONE  = 2'h1;
   localparam logic [CERR_W-1:0] CERR_ZERO = 2'h0;
   localparam logic [NAK_W-1:0]  NAK_ONE   = 4'h1;
   localparam logic [NAK_W-1:0]  NAK_ZERO  = 4'h0;

   // Outcome of one split transaction as reported by the host engine
   typedef enum logic [2:0]
   {
      RES_ACK     = 3'b000,
      RES_NAK     = 3'b001,
      RES_NYET    = 3'b010,
      RES_NO_RESP = 3'b011,
      RES_BAD     = 3'b100,
      RES_BABBLE  = 3'b101
   } txn_result_e;

   typedef struct packed
   {
      txn_result_e        result;
      logic [BYTES_W-1:0] byte_count;
      logic               next_toggle;
   } txn_report_s;

endpackage

// ==== src/desc_word_store.sv ====
// Holding register for the entry status word with a registered read side
`timescale 1ns/1ps
`default_nettype none

module desc_word_store
#(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] RESET_VAL = 32'h0000_0000
)
(
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic             wr_en_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic      [WIDTH-1:0] word_out
);

   logic [WIDTH-1:0] word_reg;
   logic [WIDTH-1:0] word_next;

   // Keep the stored word unless a merged update arrives
   assign word_next = wr_en_in ? wr_data_in : word_reg;

   // Synchronous reset to a known empty entry
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         word_reg <= RESET_VAL;
      else
         word_reg <= word_next;
   end

   assign word_out = word_reg;

endmodule

`default_nettype wire

// ==== tb/split_bulk_desc_status_props.sv ====
// Port-level checks for the split descriptor write-back block
`timescale 1ns/1ps
`default_nettype none

module split_bulk_desc_status_props
(
   input wire logic                        clk_in,
   input wire logic                        nrst_in,
   input wire logic [4:0]                  addr_in,
   input wire logic [31:0]                 wr_data_in,
   input wire logic                        wr_en_in,
   input wire logic                        rd_en_in,
   input wire logic                        report_valid_in,
   input wire split_desc_pkg::txn_report_s report_in,
   input wire logic [31:0]                 rd_data_out,
   input wire logic                        irq_out,
   input wire logic                        valid_out,
   input wire logic                        active_out,
   input wire logic                        split_phase_out,
   input wire logic                        toggle_out
);
   // Report taken with no software write in the same cycle
   wire logic       take;
   wire logic [2:0] res;
   assign take = report_valid_in && valid_out && !wr_en_in;
   assign res = report_in.result;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   AST_RD_IDLE: assert property (!$past(rd_en_in) |-> rd_data_out == '0)
      else $error("read data not zero outside read cycle");
   AST_BABBLE: assert property (take && res == split_desc_pkg::RES_BABBLE
      |=> !active_out && !valid_out)
      else $error("babble did not retire entry");
   AST_ACK_START: assert property (take && !split_phase_out
      && res == split_desc_pkg::RES_ACK |=> split_phase_out
      && toggle_out == $past(report_in.next_toggle))
      else $error("start split success not written back");
   AST_ACK_DONE: assert property (take && res == split_desc_pkg::RES_ACK
      && split_phase_out |=> !split_phase_out && !valid_out && !active_out)
      else $error("complete split success not retired");
   AST_NAK_HOLD: assert property (take && (res == split_desc_pkg::RES_NAK
      || res == split_desc_pkg::RES_NYET)
      |=> $stable(toggle_out) && $stable(split_phase_out))
      else $error("handshake retry changed phase or toggle");
   AST_ERR_HOLD: assert property (take && (res == split_desc_pkg::RES_BAD
      || res == split_desc_pkg::RES_NO_RESP)
      |=> $stable(toggle_out) && $stable(split_phase_out))
      else $error("failed transaction changed phase or toggle");
   AST_IDLE_HOLD: assert property (!report_valid_in && !wr_en_in
      && !$past(report_valid_in) && !$past(wr_en_in)
      |=> $stable(split_phase_out) && $stable(toggle_out)
      && $stable(active_out))
      else $error("entry bits moved without cause");
   AST_IRQ_CAUSE: assert property ($rose(irq_out)
      |-> $past(report_valid_in) || $past(report_valid_in, 2)
      || $past(wr_en_in) || $past(wr_en_in, 2) || $past(wr_en_in, 3))
      else $error("interrupt rose without event or mask write");
endmodule

bind split_bulk_desc_status split_bulk_desc_status_props props_i
(
   .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
   .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
   .report_valid_in(report_valid_in), .report_in(report_in),
   .rd_data_out(rd_data_out), .irq_out(irq_out), .valid_out(valid_out),
   .active_out(active_out), .split_phase_out(split_phase_out),
   .toggle_out(toggle_out)
);

`default_nettype wire

// ==== tb/txn_engine_model.sv ====
// Far-side model: reports one split outcome after a chosen delay
`timescale 1ns/1ps
`default_nettype none

module txn_engine_model
(
   input  wire logic                        clk_in,
   input  wire logic                        go_in,
   input  wire logic [3:0]                  delay_in,
   input  wire split_desc_pkg::txn_report_s rep_in,
   output var  logic                        report_valid_out,
   output var  split_desc_pkg::txn_report_s report_out
);
   logic [4:0] wait_reg = 5'h00;

   initial
   begin
      report_valid_out = 1'b0;
      report_out = '0;
   end

   // One pulse per request; report lines scrambled once released
   always @(posedge clk_in)
   begin
      report_valid_out <= 1'b0;
      if (report_valid_out)
         report_out <= ~report_out;
      if (go_in)
         wait_reg <= {1'b1, delay_in};
      else if (wait_reg == 5'h10)
      begin
         report_valid_out <= 1'b1;
         report_out <= rep_in;
         wait_reg <= 5'h00;
      end
      else if (wait_reg[4])
         wait_reg <= wait_reg - 5'h01;
   end
endmodule

`default_nettype wire

// ==== tb/split_bulk_desc_status_bench.sv ====
// Self-checking bench for the split descriptor write-back block
`timescale 1ns/1ps
`default_nettype none

module split_bulk_desc_status_bench;
   logic                        clk_in;
   logic                        nrst_in;
   logic [4:0]                  addr_in;
   logic [31:0]                 wr_data_in;
   logic                        wr_en_in;
   logic                        rd_en_in;
   logic                        report_valid_in;
   split_desc_pkg::txn_report_s report_in;
   split_desc_pkg::txn_report_s rep;
   logic [31:0]                 rd_data_out;
   logic                        irq_out;
   logic                        valid_out;
   logic                        active_out;
   logic                        split_phase_out;
   logic                        toggle_out;
   logic                        go;
   logic [3:0]                  delay;
   logic [31:0]                 rdat;
   int                          num_errors;
   int                          comparisons;
   int                          cycles = 0;

   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   split_bulk_desc_status dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
      .rd_en_in(rd_en_in), .report_valid_in(report_valid_in),
      .report_in(report_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
      .valid_out(valid_out), .active_out(active_out),
      .split_phase_out(split_phase_out), .toggle_out(toggle_out));

   txn_engine_model engine (.clk_in(clk_in), .go_in(go),
      .delay_in(delay), .rep_in(rep),
      .report_valid_out(report_valid_in), .report_out(report_in));

   task automatic check(input string n, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1;
      rdat = rd_data_out;
   endtask

   // Ask the far side for one outcome, return once it has landed
   task automatic send(input split_desc_pkg::txn_result_e r,
                       input logic [14:0] n, input logic t);
      int i;
      @(posedge clk_in);
      rep <= '{r, n, t};
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      for (i = 0; i < 20 && report_valid_in !== 1'b1; i++)
         @(posedge clk_in) #1;
      @(posedge clk_in) #1;
   endtask

   task automatic t_reset();
      int a;
      check("outs", {irq_out, valid_out, active_out, split_phase_out,
                     toggle_out}, 32'h0000_0000);
      wr(5'h10, 32'hFFFF_FFFF);
      for (a = 0; a < 20; a += 4)
      begin
         rd(5'(a));
         check("reset", rdat, 32'h0000_0000);
      end
      wr(split_desc_pkg::OFF_ENTRY_WORD, 32'hFFFF_FFFF);
      rd(split_desc_pkg::OFF_ENTRY_WORD);
      check("used", rdat, split_desc_pkg::WORD_USED_MASK);
      wr(split_desc_pkg::OFF_ENTRY_WORD, 32'h0000_0000);
      $display("test reset done");
   endtask

   // Start then complete split, then a report on a retired entry
   task automatic t_ack();
      delay = 4'h0;
      wr(split_desc_pkg::OFF_IRQ_MASK, 32'h0000_000F);
      wr(split_desc_pkg::OFF_CONTROL, 32'h0000_0001);
      wr(split_desc_pkg::OFF_ENTRY_WORD, 32'h8180_0000);
      send(split_desc_pkg::RES_ACK, 15'h0040, 1'b1);
      check("phase", split_phase_out, 32'h0000_0001);
      check("toggle", toggle_out, 32'h0000_0001);
      rd(split_desc_pkg::OFF_ENTRY_WORD);
      check("word", rdat, 32'h8B80_0040);
      delay = 4'h3;
      send(split_desc_pkg::RES_ACK, 15'h7FFF, 1'b0);
      check("done", {split_phase_out, active_out, valid_out}, 0);
      rd(split_desc_pkg::OFF_ENTRY_WORD);
      check("word", rdat, 32'h0180_7FFF);
      check("irq", irq_out, 32'h0000_0001);
      rd(split_desc_pkg::OFF_IRQ_STATUS);
      check("status", rdat, 32'h0000_0001);
      repeat (2) @(posedge clk_in) #1;
      check("irq", irq_out, 32'h0000_0000);
      send(split_desc_pkg::RES_ACK, 15'h0001, 1'b1);
      check("refused", {split_phase_out, toggle_out}, 0);
      $display("test ack done");
   endtask

   // Babble with the interrupt masked, then unmasked and cleared
   task automatic t_babble();
      wr(split_desc_pkg::OFF_IRQ_MASK, 32'h0000_0000);
      wr(split_desc_pkg::OFF_CONTROL, 32'h0000_0001);
      wr(split_desc_pkg::OFF_ENTRY_WORD, 32'h8180_0000);
      send(split_desc_pkg::RES_BABBLE, 15'h0010, 1'b0);
      check("retired", {active_out, valid_out}, 0);
      rd(split_desc_pkg::OFF_ENTRY_WORD);
      check("flags", rdat & 32'hF000_0000, 32'h6000_0000);
      check("masked", irq_out, 32'h0000_0000);
      wr(split_desc_pkg::OFF_IRQ_MASK, 32'h0000_0002);
      repeat (2) @(posedge clk_in) #1;
      check("irq", irq_out, 32'h0000_0001);
      rd(split_desc_pkg::OFF_IRQ_STATUS);
      check("status", rdat, 32'h0000_0002);
      repeat (2) @(posedge clk_in) #1;
      check("irq", irq_out, 32'h0000_0000);
      $display("test babble done");
   endtask

   // Retry count walk: nibbles hold outcome codes and expected counts
   task automatic t_errors();
      logic [31:0] seq = 32'h4134_2333;
      logic [31:0] cnt = 32'h2321_3210;
      int          i;
      wr(split_desc_pkg::OFF_CONTROL, 32'h0000_0001);
      wr(split_desc_pkg::OFF_ENTRY_WORD, 32'h8180_0000);
      for (i = 0; i < 8; i++)
      begin
         delay = 4'(i);
         send(split_desc_pkg::txn_result_e'(seq[28-4*i +: 3]),
              15'h0000, 1'b0);
         rd(split_desc_pkg::OFF_ENTRY_WORD);
         check("retry", rdat[24:23], cnt[28-4*i +: 2]);
         check("live", valid_out, i != 7);
         if (i == 0)
            check("fault", rdat[28], 32'h0000_0001);
      end
      rd(split_desc_pkg::OFF_IRQ_STATUS);
      check("status", rdat, 32'h0000_0004);
      $display("test errors done");
   endtask

   // Negative-ack retirement, then no counting or retirement on an isochronous entry
   task automatic t_nak();
      delay = 4'h1;
      wr(split_desc_pkg::OFF_CONTROL, 32'h0000_0009);
      wr(split_desc_pkg::OFF_ENTRY_WORD, 32'h8190_0000);
      send(split_desc_pkg::RES_NAK, 15'h0000, 1'b0);
      rd(split_desc_pkg::OFF_ENTRY_WORD);
      check("nak", rdat & 32'h0078_0000, 32'h0008_0000);
      check("live", valid_out, 32'h0000_0001);
      send(split_desc_pkg::RES_NAK, 15'h0000, 1'b0);
      check("retired", {active_out, valid_out}, 0);
      rd(split_desc_pkg::OFF_IRQ_STATUS);
      check("status", rdat, 32'h0000_0008);
      wr(split_desc_pkg::OFF_CONTROL, 32'h0000_000B);
      wr(split_desc_pkg::OFF_ENTRY_WORD, 32'h8190_0000);
      repeat (3) send(split_desc_pkg::RES_NAK, 15'h0000, 1'b0);
      check("iso", valid_out, 32'h0000_0001);
      rd(split_desc_pkg::OFF_ENTRY_WORD);
      check("iso nak", rdat & 32'h0078_0000, 32'h0010_0000);
      $display("test nak done");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   initial
   begin
      nrst_in = 1'b0;
      addr_in = 5'h00;
      wr_data_in = 32'h0000_0000;
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      go = 1'b0;
      delay = 4'h0;
      rep = '0;
      num_errors = 0;
      comparisons = 0;
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_ack();
      t_babble();
      t_errors();
      t_nak();
      give_verdict();
   end
endmodule

`default_nettype wire
